// ===== stl_pkg.sv
//------------------------------------------------------------
// supply tracking limiter with brown-out guard: constants
//------------------------------------------------------------
// Notes on behaviour
// - brownout guard only when enabled, overrides limiter
// - select bit picks battery or boost rail
// - below threshold: attenuate at brownout attack rate
// - above threshold: hold count, then limiter release
// - limiter gain frozen during brownout event
// - infinite hold keeps attenuation until cleared
// - hold clear bit self clears after release
// - shutdown when battery below shutdown threshold
// - one maximum attenuation shared by both functions
// - no further attack once maximum is reached
// - mode: off, battery, boost rail, reserved
// - headroom mode: threshold is slope times supply
// - fixed mode: max, sloped below inflection, min floor
// - limiter attack, hold, release fields of 24 bits
package stl_pkg;
   localparam int unsigned DW = 24;
   localparam int unsigned SW = 24;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_BO_THR   = 8'h04;
   localparam logic [7:0] OFS_BO_ATK   = 8'h08;
   localparam logic [7:0] OFS_BO_HLD   = 8'h0c;
   localparam logic [7:0] OFS_SD_THR   = 8'h10;
   localparam logic [7:0] OFS_MAX_ATN  = 8'h14;
   localparam logic [7:0] OFS_SLOPE    = 8'h18;
   localparam logic [7:0] OFS_TH_MAX   = 8'h1c;
   localparam logic [7:0] OFS_TH_MIN   = 8'h20;
   localparam logic [7:0] OFS_INF_PT   = 8'h24;
   localparam logic [7:0] OFS_L_ATK    = 8'h28;
   localparam logic [7:0] OFS_L_HLD    = 8'h2c;
   localparam logic [7:0] OFS_L_RLS    = 8'h30;
   localparam logic [7:0] OFS_STATUS   = 8'h34;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
   localparam logic [7:0] OFS_GAIN     = 8'h3c;
   // control register fields
   localparam int unsigned CB_BO_EN    = 0;
   localparam int unsigned CB_BO_SRC   = 1;
   localparam int unsigned CB_INF_HLD  = 2;
   localparam int unsigned CB_HLD_CLR  = 3;
   localparam int unsigned CB_SD_EN    = 4;
   localparam int unsigned CB_HEADROOM = 5;
   localparam int unsigned CB_MODE_LO  = 6;
   localparam int unsigned CTRL_W      = 8;
   // status / interrupt bits
   localparam int unsigned ST_BO       = 0;
   localparam int unsigned ST_LIM      = 1;
   localparam int unsigned ST_SD       = 2;
   localparam int unsigned ST_W        = 3;
   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
   localparam logic [DW-1:0]     ZERO24   = 24'h000000;
   localparam logic [DW-1:0]     MAXA_RST = 24'h0c0000;
   // limiter mode encodings
   localparam logic [1:0] MODE_OFF  = 2'b00;
   localparam logic [1:0] MODE_BATT = 2'b01;
   localparam logic [1:0] MODE_RAIL = 2'b10;
   // slope is unsigned fixed point with this many fraction bits
   localparam int unsigned SLOPE_FRAC = 20;
   typedef enum logic [1:0] {
      BO_IDLE   = 2'b00,
      BO_ATTACK = 2'b01,
      BO_HOLD   = 2'b10,
      BO_REL    = 2'b11
   } stl_bo_e;
endpackage : stl_pkg

// ===== stl_limiter.sv
`timescale 1ns/10ps
module stl_limiter
   import stl_pkg::*;
(
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic      [31:0]   hrdata,
   output logic               hreadyout,
   output logic               hresp,
   input  wire logic          sample_valid,
   input  wire logic [DW-1:0] sample_in,
   input  wire logic [SW-1:0] battery_level,
   input  wire logic [SW-1:0] boost_rail_supply,
   output logic               out_valid,
   output logic      [DW-1:0] sample_out,
   output logic               brownout_active,
   output logic               limiter_active,
   output logic               shutdown,
   output logic               irq
);
   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   // saturating unsigned add, bounded by a ceiling
   function automatic logic [DW-1:0] sat_add(input logic [DW-1:0] a,
                                             input logic [DW-1:0] b,
                                             input logic [DW-1:0] c);
      logic [DW:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s > {1'b0, c})
         sat_add = c;
      else
         sat_add = s[DW-1:0];
   endfunction : sat_add
   // saturating unsigned subtract
   function automatic logic [DW-1:0] sat_sub(input logic [DW-1:0] a,
                                             input logic [DW-1:0] b);
      if (b > a)
         sat_sub = ZERO24;
      else
         sat_sub = a - b;
   endfunction : sat_sub
   // fixed point multiply by slope, saturated to 24 bits
   function automatic logic [DW-1:0] mul_slope(input logic [DW-1:0] a,
                                               input logic [DW-1:0] s);
      logic [2*DW-1:0] p;
      p = a * s;
      if (|p[2*DW-1:DW+SLOPE_FRAC])
         mul_slope = 24'hffffff;
      else
         mul_slope = p[DW+SLOPE_FRAC-1:SLOPE_FRAC];
   endfunction : mul_slope

   //------------------------------------------------------------
   // input synchronisers
   //------------------------------------------------------------
   logic [SW-1:0] batt_m_r, batt_r, rail_m_r, rail_r;
   // readings come from the monitor's clock: two flops before use
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         batt_m_r <= ZERO24;
         batt_r   <= ZERO24;
         rail_m_r <= ZERO24;
         rail_r   <= ZERO24;
      end
      else
      begin
         batt_m_r <= battery_level;
         batt_r   <= batt_m_r;
         rail_m_r <= boost_rail_supply;
         rail_r   <= rail_m_r;
      end
   end

   //------------------------------------------------------------
   // register file state
   //------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [DW-1:0] bo_thr_r, bo_atk_r, bo_hld_r, sd_thr_r, max_atn_r;
   logic [DW-1:0] slope_r, th_max_r, th_min_r, inf_pt_r;
   logic [DW-1:0] l_atk_r, l_hld_r, l_rls_r;
   logic [ST_W-1:0] status_r, status_nxt, mask_r;
   logic          aph_r;
   logic          awr_r;
   logic [7:0]    aadr_r;
   logic [31:0]   hrdata_nxt;
   logic          hld_clr_done;
   logic [ST_W-1:0] ev;
   logic [DW-1:0] tot_atn;    // combined attenuation, also read back

   // address phase capture and write decode
   wire take = hsel & hready & htrans[1];
   wire wr   = aph_r & awr_r;
   wire rd   = aph_r & ~awr_r;

   always_comb
   begin
      ctrl_nxt = ctrl_r;
      // self clear first, so a software write in the same cycle wins
      if (hld_clr_done)
         ctrl_nxt[CB_HLD_CLR] = 1'b0;
      if (wr && aadr_r == OFS_CTRL)
         ctrl_nxt = hwdata[CTRL_W-1:0];
      status_nxt = status_r;
      if (rd && aadr_r == OFS_STATUS)
         status_nxt = '0;
      status_nxt = status_nxt | ev;                      // set wins
   end

   // read mux for the data phase that follows
   always_comb
   begin
      hrdata_nxt = 32'h00000000;
      if (take && !hwrite)
         case (haddr[7:0])
            OFS_CTRL:     hrdata_nxt = {24'h000000, ctrl_r};
            OFS_BO_THR:   hrdata_nxt = {8'h00, bo_thr_r};
            OFS_BO_ATK:   hrdata_nxt = {8'h00, bo_atk_r};
            OFS_BO_HLD:   hrdata_nxt = {8'h00, bo_hld_r};
            OFS_SD_THR:   hrdata_nxt = {8'h00, sd_thr_r};
            OFS_MAX_ATN:  hrdata_nxt = {8'h00, max_atn_r};
            OFS_SLOPE:    hrdata_nxt = {8'h00, slope_r};
            OFS_TH_MAX:   hrdata_nxt = {8'h00, th_max_r};
            OFS_TH_MIN:   hrdata_nxt = {8'h00, th_min_r};
            OFS_INF_PT:   hrdata_nxt = {8'h00, inf_pt_r};
            OFS_L_ATK:    hrdata_nxt = {8'h00, l_atk_r};
            OFS_L_HLD:    hrdata_nxt = {8'h00, l_hld_r};
            OFS_L_RLS:    hrdata_nxt = {8'h00, l_rls_r};
            OFS_STATUS:   hrdata_nxt = {29'h00000000, status_r};
            OFS_IRQ_MASK: hrdata_nxt = {29'h00000000, mask_r};
            OFS_GAIN:     hrdata_nxt = {8'h00, tot_atn};
            default:      hrdata_nxt = 32'h00000000;
         endcase
   end

   // register writes and bus phase state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         aph_r <= 1'b0; awr_r <= 1'b0; aadr_r <= 8'h00;
         hrdata <= 32'h00000000;
         ctrl_r <= CTRL_RST; status_r <= '0; mask_r <= '0;
         bo_thr_r <= ZERO24; bo_atk_r <= ZERO24; bo_hld_r <= ZERO24;
         sd_thr_r <= ZERO24; max_atn_r <= MAXA_RST; slope_r <= ZERO24;
         th_max_r <= ZERO24; th_min_r <= ZERO24; inf_pt_r <= ZERO24;
         l_atk_r <= ZERO24; l_hld_r <= ZERO24; l_rls_r <= ZERO24;
      end
      else
      begin
         aph_r  <= take;
         awr_r  <= hwrite;
         aadr_r <= haddr[7:0];
         hrdata <= hrdata_nxt;
         ctrl_r <= ctrl_nxt;
         status_r <= status_nxt;
         if (wr)
            case (aadr_r)
               OFS_BO_THR:   bo_thr_r  <= hwdata[DW-1:0];
               OFS_BO_ATK:   bo_atk_r  <= hwdata[DW-1:0];
               OFS_BO_HLD:   bo_hld_r  <= hwdata[DW-1:0];
               OFS_SD_THR:   sd_thr_r  <= hwdata[DW-1:0];
               OFS_MAX_ATN:  max_atn_r <= hwdata[DW-1:0];
               OFS_SLOPE:    slope_r   <= hwdata[DW-1:0];
               OFS_TH_MAX:   th_max_r  <= hwdata[DW-1:0];
               OFS_TH_MIN:   th_min_r  <= hwdata[DW-1:0];
               OFS_INF_PT:   inf_pt_r  <= hwdata[DW-1:0];
               OFS_L_ATK:    l_atk_r   <= hwdata[DW-1:0];
               OFS_L_HLD:    l_hld_r   <= hwdata[DW-1:0];
               OFS_L_RLS:    l_rls_r   <= hwdata[DW-1:0];
               OFS_IRQ_MASK: mask_r    <= hwdata[ST_W-1:0];
               default:      ;
            endcase
      end
   end

   //------------------------------------------------------------
   // threshold and detection
   //------------------------------------------------------------
   // fixed mode: max above the knee, sloped below it, floored at min
   logic [1:0]    mode;
   logic [SW-1:0] lim_sup, bo_sup;
   logic [DW-1:0] lim_thr, drop, mag;
   logic          lim_on, bo_low, lim_over;
   always_comb
   begin
      mode    = ctrl_r[CB_MODE_LO +: 2];
      lim_on  = (mode == MODE_BATT) || (mode == MODE_RAIL);
      lim_sup = (mode == MODE_RAIL) ? rail_r : batt_r;
      bo_sup  = ctrl_r[CB_BO_SRC] ? rail_r : batt_r;
      bo_low  = ctrl_r[CB_BO_EN] && (bo_sup < bo_thr_r);
      drop    = mul_slope(sat_sub(inf_pt_r, lim_sup), slope_r);
      if (ctrl_r[CB_HEADROOM])
         lim_thr = mul_slope(lim_sup, slope_r);
      else if (lim_sup >= inf_pt_r)
         lim_thr = th_max_r;
      else if (sat_sub(th_max_r, drop) < th_min_r)
         lim_thr = th_min_r;
      else
         lim_thr = sat_sub(th_max_r, drop);
      mag      = sample_in[DW-1] ? (~sample_in + 24'h000001) : sample_in;
      lim_over = lim_on && (mag > lim_thr);
   end

   //------------------------------------------------------------
   // per-sample gain state machines
   //------------------------------------------------------------
   stl_bo_e       bo_st_r, bo_st_nxt;
   logic [DW-1:0] bo_atn_r, bo_atn_nxt, lim_atn_r, lim_atn_nxt;
   logic [DW-1:0] bo_cnt_r, bo_cnt_nxt, l_cnt_r, l_cnt_nxt;
   logic          sd_r, sd_nxt;
   // combined attenuation, bounded by the shared maximum
   always_comb tot_atn = sat_add(bo_atn_r, lim_atn_r, max_atn_r);

   // all gain state except the shutdown flag moves only on an audio sample strobe
   always_comb
   begin
      bo_st_nxt    = bo_st_r;
      bo_atn_nxt   = bo_atn_r;
      lim_atn_nxt  = lim_atn_r;
      bo_cnt_nxt   = bo_cnt_r;
      l_cnt_nxt    = l_cnt_r;
      hld_clr_done = 1'b0;
      sd_nxt = sd_r | (ctrl_r[CB_SD_EN] && batt_r < sd_thr_r);
      if (sample_valid)
      begin
         case (bo_st_r)
            BO_IDLE:
               if (bo_low)
                  bo_st_nxt = BO_ATTACK;
            BO_ATTACK:
            begin
               // budget left is max minus what the limiter holds
               bo_atn_nxt = sat_add(bo_atn_r, bo_atk_r,
                                    sat_sub(max_atn_r, lim_atn_r));
               if (!bo_low)
               begin
                  bo_st_nxt  = BO_HOLD;
                  bo_cnt_nxt = bo_hld_r;
               end
            end
            BO_HOLD:
               if (bo_low)
                  bo_st_nxt = BO_ATTACK;
               else if (ctrl_r[CB_INF_HLD] && !ctrl_r[CB_HLD_CLR])
                  bo_st_nxt = BO_HOLD;
               else if (bo_cnt_r == ZERO24 || ctrl_r[CB_INF_HLD])
               begin
                  bo_st_nxt    = BO_REL;
                  hld_clr_done = ctrl_r[CB_HLD_CLR];
               end
               else
                  bo_cnt_nxt = bo_cnt_r - 24'h000001;
            BO_REL:
               if (bo_low)
                  bo_st_nxt = BO_ATTACK;
               else
               begin
                  bo_atn_nxt = sat_sub(bo_atn_r, l_rls_r);
                  if (bo_atn_nxt == ZERO24)
                     bo_st_nxt = BO_IDLE;
               end
            default:
               bo_st_nxt = BO_IDLE;
         endcase
         // limiter frozen whenever the brownout guard is busy
         if (bo_st_r == BO_IDLE && !bo_low)
         begin
            if (lim_over)
            begin
               lim_atn_nxt = sat_add(lim_atn_r, l_atk_r,
                                     sat_sub(max_atn_r, bo_atn_r));
               l_cnt_nxt   = l_hld_r;
            end
            else if (l_cnt_r != ZERO24)
               l_cnt_nxt = l_cnt_r - 24'h000001;
            else
               lim_atn_nxt = sat_sub(lim_atn_r, l_rls_r);
            if (!lim_on)
               lim_atn_nxt = ZERO24;
         end
      end
      // a clear with no hold pending is simply dropped
      if (ctrl_r[CB_HLD_CLR] && bo_st_r != BO_HOLD)
         hld_clr_done = 1'b1;
   end

   // events for the sticky status register
   // each event sets its bit; a read of status clears them
   always_comb
   begin
      ev = '0;
      ev[ST_BO]  = (bo_st_r == BO_IDLE) && bo_low && sample_valid;
      ev[ST_LIM] = (lim_atn_r == ZERO24) && (lim_atn_nxt != ZERO24);
      ev[ST_SD]  = sd_nxt && !sd_r;
   end

   // output sample with attenuation as a linear scale factor
   // half the scale is multiplied, so the product is shifted by 22
   // and zero attenuation passes the sample unchanged
   logic [2*DW-1:0] prod;
   logic [DW-1:0]   scale;
   always_comb
   begin
      scale = sat_sub(24'h800000, tot_atn);
      prod  = $signed(sample_in) * $signed({1'b0, scale[DW-1:1]});
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bo_st_r <= BO_IDLE; bo_atn_r <= ZERO24; lim_atn_r <= ZERO24;
         bo_cnt_r <= ZERO24; l_cnt_r <= ZERO24; sd_r <= 1'b0;
         out_valid <= 1'b0; sample_out <= ZERO24;
         brownout_active <= 1'b0; limiter_active <= 1'b0;
         shutdown <= 1'b0; irq <= 1'b0;
      end
      else
      begin
         bo_st_r   <= bo_st_nxt;
         bo_atn_r  <= bo_atn_nxt;
         lim_atn_r <= lim_atn_nxt;
         bo_cnt_r  <= bo_cnt_nxt;
         l_cnt_r   <= l_cnt_nxt;
         sd_r      <= sd_nxt;
         out_valid <= sample_valid & ~sd_nxt;
         sample_out <= sd_nxt ? ZERO24 : prod[2*DW-3:DW-2];
         brownout_active <= (bo_st_nxt != BO_IDLE);
         limiter_active  <= (lim_atn_nxt != ZERO24);
         shutdown <= sd_nxt;
         irq <= |(status_nxt & mask_r);
      end
   end

   // no wait states: every transfer ends in its data phase
   // hsize is ignored and the response is always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
endmodule : stl_limiter

// ===== stl_limiter_monitor.sv
`timescale 1ns/10ps
module stl_limiter_monitor
   import stl_pkg::*;
(
   input wire logic          hclk,
   input wire logic          hresetn,
   input wire logic          sample_valid,
   input wire logic [DW-1:0] sample_in,
   input wire logic          out_valid,
   input wire logic [DW-1:0] sample_out,
   input wire logic          brownout_active,
   input wire logic          limiter_active,
   input wire logic          shutdown
);
   logic [DW:0] in_mag;
   logic [DW:0] out_mag;
   // magnitudes; one count of slack covers rounding of negative samples
   always_comb
   begin
      in_mag  = sample_in[DW-1] ? {1'b0, -sample_in} : {1'b0, sample_in};
      out_mag = sample_out[DW-1] ? {1'b0, -sample_out} : {1'b0, sample_out};
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   //--------------------------------------------------------
   // sequences and properties
   //--------------------------------------------------------
   sequence s_bo_held; brownout_active [*2]; endsequence
   sequence s_live_sample; (sample_valid && !shutdown) ##1 !shutdown;
   endsequence
   property p_out_cause; out_valid |-> $past(sample_valid) && !shutdown;
   endproperty
   property p_out_pulse; s_live_sample |-> out_valid; endproperty
   property p_out_mag; out_valid |-> out_mag <= $past(in_mag) + 25'h1;
   endproperty
   property p_sd_sticky; shutdown |=> shutdown; endproperty
   property p_sd_mute; $past(shutdown) |-> !out_valid; endproperty
   property p_freeze; s_bo_held |-> $stable(limiter_active); endproperty
   property p_bo_rise; $rose(brownout_active) |-> $past(sample_valid);
   endproperty
   property p_lim_rise; $rose(limiter_active) |-> $past(sample_valid);
   endproperty
   property p_lim_fall;
      $fell(limiter_active) |-> $past(sample_valid) && !$past(brownout_active);
   endproperty
   a_out_cause: assert property (p_out_cause)
      else $error("output sample without input sample");
   a_out_pulse: assert property (p_out_pulse)
      else $error("input sample produced no output");
   a_out_mag: assert property (p_out_mag)
      else $error("output louder than input");
   a_sd_sticky: assert property (p_sd_sticky)
      else $error("shutdown released");
   a_sd_mute: assert property (p_sd_mute)
      else $error("output while shut down");
   a_freeze: assert property (p_freeze)
      else $error("limiter moved during brownout");
   a_bo_rise: assert property (p_bo_rise)
      else $error("brownout started off a sample");
   a_lim_rise: assert property (p_lim_rise)
      else $error("limiter started off a sample");
   a_lim_fall: assert property (p_lim_fall)
      else $error("limiter released at wrong time");
endmodule : stl_limiter_monitor
bind stl_limiter stl_limiter_monitor stl_limiter_monitor_inst (
   .hclk(hclk), .hresetn(hresetn), .sample_valid(sample_valid),
   .sample_in(sample_in), .out_valid(out_valid), .sample_out(sample_out),
   .brownout_active(brownout_active), .limiter_active(limiter_active),
   .shutdown(shutdown));

// ===== stl_src_model.sv
`timescale 1ns/10ps
module stl_src_model
   import stl_pkg::*;
(
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic [SW-1:0] batt_set,
   input  wire logic [SW-1:0] rail_set,
   input  wire logic [DW-1:0] amp,
   output logic               sample_valid,
   output logic      [DW-1:0] sample_in,
   output logic      [SW-1:0] battery_level,
   output logic      [SW-1:0] boost_rail_supply
);
   logic [2:0] cnt_r;
   logic       sign_r;
   // one sample every eight clocks, alternating polarity
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_r        <= 3'h0;
         sign_r       <= 1'b0;
         sample_valid <= 1'b0;
         sample_in    <= 24'h000000;
      end
      else
      begin
         cnt_r        <= cnt_r + 3'h1;
         sample_valid <= (cnt_r == 3'h7);
         if (cnt_r == 3'h7)
         begin
            sign_r    <= ~sign_r;
            sample_in <= sign_r ? -amp : amp;
         end
      end
   end
   // supply monitor readings follow the bench settings
   assign battery_level     = batt_set;
   assign boost_rail_supply = rail_set;
endmodule : stl_src_model

// ===== tb.sv
`timescale 1ns/10ps
module tb;
   import stl_pkg::*;
   logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]   haddr, hwdata, hrdata, rd_v;
   logic [1:0]    htrans;
   logic [2:0]    hsize;
   logic          sample_valid, out_valid, brownout_active, limiter_active;
   logic          shutdown, irq;
   logic [DW-1:0] sample_in, sample_out, amp;
   logic [SW-1:0] battery_level, boost_rail_supply, batt_set, rail_set;
   int            n_mismatch;
   int            samples_checked;
   assign hready = hreadyout;
   stl_limiter stl_limiter_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
      .sample_in(sample_in), .battery_level(battery_level),
      .boost_rail_supply(boost_rail_supply), .out_valid(out_valid),
      .sample_out(sample_out), .brownout_active(brownout_active),
      .limiter_active(limiter_active), .shutdown(shutdown), .irq(irq));
   stl_src_model stl_src_model_inst (.hclk(hclk), .hresetn(hresetn),
      .batt_set(batt_set), .rail_set(rail_set), .amp(amp),
      .sample_valid(sample_valid), .sample_in(sample_in),
      .battery_level(battery_level), .boost_rail_supply(boost_rail_supply));
   // 50 ns clock
   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   //--------------------------------------------------------
   // shared tasks
   //--------------------------------------------------------
   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task edge_wait;
      int i;
      i = 0;
      do
      begin
         @(posedge hclk);
         i++;
      end while (hready !== 1'b1 && i < 50);
      if (hready !== 1'b1)
      begin
         n_mismatch++;
         complete_run();
      end
   endtask : edge_wait
   // one ahb single word transfer; read data taken at the data edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      edge_wait();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      edge_wait();
      rd_v = hrdata;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h00000000);
      chk(rd_v, exp);
   endtask : rdc
   task samples(input int n);
      repeat (n * 8) @(posedge hclk);
   endtask : samples
   // bounded wait for a status flag: 0 brownout, 1 limiter, 2 shutdown
   task wait_flag(input int sel, input logic v);
      logic f;
      for (int i = 0; i < 800; i++)
      begin
         @(posedge hclk);
         f = (sel == 0) ? brownout_active : (sel == 1) ? limiter_active
                                                       : shutdown;
         if (f === v)
            break;
      end
      chk(32'(f), 32'(v));
      if (f !== v)
         complete_run();
   endtask : wait_flag
   //--------------------------------------------------------
   // main sequence
   //--------------------------------------------------------
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      batt_set = 24'h600000;
      rail_set = 24'h600000;
      amp = 24'h100000;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(OFS_CTRL, 32'h00000000);
      rdc(OFS_MAX_ATN, {8'h00, MAXA_RST});
      rdc(OFS_STATUS, 32'h00000000);
      for (int i = 0; i < 16 && out_valid !== 1'b1; i++)
         @(posedge hclk);
      chk(32'(out_valid), 32'h1);
      chk(32'(sample_out), 32'(sample_in));
      chk(32'(hresp), 32'h0);
      for (int k = 1; k < 13; k++)
      begin
         wr(8'(k * 4), 32'hffffffff);
         rdc(8'(k * 4), 32'h00ffffff);
      end
      wr(8'h40, 32'h00001234);
      rdc(8'h40, 32'h00000000);
      $display("test registers done");
      wr(OFS_BO_THR, 32'h00400000);
      wr(OFS_BO_ATK, 32'h00000800);
      wr(OFS_MAX_ATN, 32'h00001000);
      wr(OFS_BO_HLD, 32'h00000004);
      wr(OFS_L_RLS, 32'h00000400);
      wr(OFS_IRQ_MASK, 32'h00000001);
      rdc(OFS_IRQ_MASK, 32'h00000001);
      batt_set <= 24'h300000;
      samples(10);
      chk(32'(brownout_active), 32'h0);
      wr(OFS_CTRL, 32'h00000003);
      samples(10);
      chk(32'(brownout_active), 32'h0);
      wr(OFS_CTRL, 32'h00000001);
      wait_flag(0, 1'b1);
      chk(32'(irq), 32'h1);
      rdc(OFS_STATUS, 32'h00000001);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h0);
      samples(10);
      rdc(OFS_GAIN, 32'h00001000);
      $display("test brownout attack done");
      batt_set <= 24'h600000;
      samples(2);
      rdc(OFS_GAIN, 32'h00001000);
      wait_flag(0, 1'b0);
      rdc(OFS_GAIN, 32'h00000000);
      $display("test brownout release done");
      wr(OFS_CTRL, 32'h00000005);
      batt_set <= 24'h300000;
      wait_flag(0, 1'b1);
      batt_set <= 24'h600000;
      samples(30);
      chk(32'(brownout_active), 32'h1);
      wr(OFS_CTRL, 32'h0000000d);
      samples(2);
      rdc(OFS_CTRL, 32'h00000005);
      wait_flag(0, 1'b0);
      $display("test infinite hold done");
      wr(OFS_TH_MAX, 32'h00080000);
      wr(OFS_L_ATK, 32'h00000100);
      wr(OFS_SLOPE, 32'h00100000);
      wr(OFS_CTRL, 32'h00000000);
      samples(10);
      chk(32'(limiter_active), 32'h0);
      wr(OFS_CTRL, 32'h00000080);
      samples(10);
      chk(32'(limiter_active), 32'h0);
      wr(OFS_CTRL, 32'h000000a0);
      samples(10);
      chk(32'(limiter_active), 32'h0);
      xfer(1'b0, OFS_STATUS, 32'h00000000);
      rail_set <= 24'h080000;
      wait_flag(1, 1'b1);
      rdc(OFS_STATUS, 32'h00000002);
      $display("test limiter done");
      wr(OFS_SD_THR, 32'h00200000);
      wr(OFS_IRQ_MASK, 32'h00000004);
      wr(OFS_CTRL, 32'h000000b1);
      batt_set <= 24'h300000;
      wait_flag(0, 1'b1);
      batt_set <= 24'h100000;
      wait_flag(2, 1'b1);
      samples(2);
      chk(32'(irq), 32'h1);
      $display("test shutdown done");
      complete_run();
   end
endmodule : tb
